/* common/tfs_pkg.sv */
// Purpose: Shared types and constants of the top-four sorter.
// Assumes: One clock, mclk, at 200 MHz; sys_rst synchronous, active high.
// Notes:   An operand is a 4-bit position tag above a 6-bit value.
package tfs_pkg;

    localparam int VAL_W      = 6;
    localparam int TAG_W      = 4;
    localparam int PIN_TAG_W  = 3;
    localparam int LANES      = 4;
    localparam int OPERANDS   = 8;
    localparam int STAGES     = 4;
    localparam int EXT_BIT    = 3;

    // Each stage must settle within one sort period; a longest time rounds down.
    localparam int SORT_PERIOD_PS = 6250;
    localparam int MCLK_PERIOD_PS = 5000;
    localparam int STAGE_CYCLES   = (SORT_PERIOD_PS / MCLK_PERIOD_PS) < 1 ? 1 : (SORT_PERIOD_PS / MCLK_PERIOD_PS);
    localparam int SORT_LATENCY   = STAGES * STAGE_CYCLES;

    // Boundary-scan constants.
    localparam int          SCAN_IR_W     = 4;
    localparam int          SCAN_ID_W     = 32;
    localparam logic [3:0]  SCAN_IR_IDCODE = 4'h1;
    localparam logic [3:0]  SCAN_IR_BYPASS = 4'hf;
    localparam logic [3:0]  SCAN_IR_RESET  = 4'h1;
    localparam logic [3:0]  SCAN_IR_CAPTURE = 4'h1;
    // Identification value is arbitrary.
    localparam logic [31:0] SCAN_IDCODE    = 32'h0000_0a01;

    typedef enum logic [1:0] {
        MODE_ENERGY   = 2'h0,
        MODE_ELECTRON = 2'h1,
        MODE_RECEIVER = 2'h2,
        MODE_SPARE    = 2'h3
    } tfs_mode_type;

    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic [VAL_W-1:0] val;
    } tfs_opr_type;

    typedef struct packed {
        logic [PIN_TAG_W-1:0] tag;
        logic [VAL_W-1:0]     val;
    } tfs_pin_opr_type;

    typedef tfs_opr_type     [LANES-1:0]    tfs_quad_type;
    typedef tfs_pin_opr_type [LANES-1:0]    tfs_pin_quad_type;
    typedef tfs_opr_type     [OPERANDS-1:0] tfs_oct_type;

    typedef struct packed {
        tfs_quad_type data;
        logic         sorted;
        logic         second;
    } tfs_word_type;

endpackage : tfs_pkg

/* hw/tfs_scan_tap.sv */
// Purpose: Boundary-scan controller with instruction decoder.
// Assumes: Scan pins are asynchronous to mclk and much slower than it.
// Notes:   Only identification is decoded; every other instruction acts as bypass.
`timescale 1ns/1ps
`default_nettype none
module tfs_scan_tap
    import tfs_pkg::*;
(
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic scanClk,
    input  wire logic scanMode,
    input  wire logic scanIn,
    output logic      scanOut,
    output logic      scanOutEn
);

    typedef enum logic [3:0] {
        TAP_RESET   = 4'h0, TAP_IDLE    = 4'h1, TAP_DR_SEL  = 4'h2, TAP_DR_CAP = 4'h3,
        TAP_DR_SH   = 4'h4, TAP_DR_EX1  = 4'h5, TAP_DR_PAU  = 4'h6, TAP_DR_EX2 = 4'h7,
        TAP_DR_UPD  = 4'h8, TAP_IR_SEL  = 4'h9, TAP_IR_CAP  = 4'ha, TAP_IR_SH  = 4'hb,
        TAP_IR_EX1  = 4'hc, TAP_IR_PAU  = 4'hd, TAP_IR_EX2  = 4'he, TAP_IR_UPD = 4'hf
    } tfs_tap_state_type;

    typedef struct packed {
        logic [2:0]            clkSync;
        logic [1:0]            modeSync;
        logic [1:0]            inSync;
        tfs_tap_state_type     st;
        logic [SCAN_IR_W-1:0]  ir;
        logic [SCAN_IR_W-1:0]  irShift;
        logic [SCAN_ID_W-1:0]  drShift;
        logic                  tdo;
        logic                  tdoEn;
    } tfs_tap_reg_type;

    tfs_tap_reg_type s, n;
    logic            rise;
    logic            fall;
    logic            tms;
    logic            isId;

    always_comb
    begin
        n    = s;
        // First sync stage feeds only the second; edges use stages two and three.
        n.clkSync  = {s.clkSync[1:0], scanClk};
        n.modeSync = {s.modeSync[0], scanMode};
        n.inSync   = {s.inSync[0], scanIn};
        rise = s.clkSync[1] & ~s.clkSync[2];
        fall = ~s.clkSync[1] & s.clkSync[2];
        tms  = s.modeSync[1];
        isId = (s.ir == SCAN_IR_IDCODE);
        if (rise)
        begin
            unique case (s.st)
                TAP_RESET:  n.st = tms ? TAP_RESET  : TAP_IDLE;
                TAP_IDLE:   n.st = tms ? TAP_DR_SEL : TAP_IDLE;
                TAP_DR_SEL: n.st = tms ? TAP_IR_SEL : TAP_DR_CAP;
                TAP_DR_CAP: n.st = tms ? TAP_DR_EX1 : TAP_DR_SH;
                TAP_DR_SH:  n.st = tms ? TAP_DR_EX1 : TAP_DR_SH;
                TAP_DR_EX1: n.st = tms ? TAP_DR_UPD : TAP_DR_PAU;
                TAP_DR_PAU: n.st = tms ? TAP_DR_EX2 : TAP_DR_PAU;
                TAP_DR_EX2: n.st = tms ? TAP_DR_UPD : TAP_DR_SH;
                TAP_DR_UPD: n.st = tms ? TAP_DR_SEL : TAP_IDLE;
                TAP_IR_SEL: n.st = tms ? TAP_RESET  : TAP_IR_CAP;
                TAP_IR_CAP: n.st = tms ? TAP_IR_EX1 : TAP_IR_SH;
                TAP_IR_SH:  n.st = tms ? TAP_IR_EX1 : TAP_IR_SH;
                TAP_IR_EX1: n.st = tms ? TAP_IR_UPD : TAP_IR_PAU;
                TAP_IR_PAU: n.st = tms ? TAP_IR_EX2 : TAP_IR_PAU;
                TAP_IR_EX2: n.st = tms ? TAP_IR_UPD : TAP_IR_SH;
                TAP_IR_UPD: n.st = tms ? TAP_DR_SEL : TAP_IDLE;
            endcase
            unique case (s.st)
                TAP_RESET:  n.ir = SCAN_IR_RESET;
                TAP_DR_CAP: n.drShift = isId ? SCAN_IDCODE : '0;
                TAP_DR_SH:  n.drShift = isId ? {s.inSync[1], s.drShift[SCAN_ID_W-1:1]}
                                             : {{(SCAN_ID_W-1){1'b0}}, s.inSync[1]};
                TAP_IR_CAP: n.irShift = SCAN_IR_CAPTURE;
                TAP_IR_SH:  n.irShift = {s.inSync[1], s.irShift[SCAN_IR_W-1:1]};
                TAP_IR_UPD: n.ir = s.irShift;
                default:    n.ir = s.ir;
            endcase
        end
        // Output changes on the falling scan edge so the far side samples it stably.
        if (fall)
        begin
            n.tdoEn = (s.st == TAP_DR_SH) || (s.st == TAP_IR_SH);
            n.tdo   = (s.st == TAP_IR_SH) ? s.irShift[0] : s.drShift[0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s    <= '0;
            s.ir <= SCAN_IR_RESET;
        end
        else
        begin
            s <= n;
        end
    end

    assign scanOut   = s.tdo;
    assign scanOutEn = s.tdoEn;

endmodule : tfs_scan_tap
`default_nettype wire

/* hw/tfs_top_four_sorter.sv */
// Purpose: Selects the four largest of eight tagged operands through a four-stage swap chain.
// Assumes: Operand inputs come from logic on mclk; scan pins are asynchronous.
// Notes:   Mode inputs are static while data flows.
//
// How it works
// - Four compare-swap stages, each with fixed rotation.
// - Operand is ten bits: tag above value.
// - Compare value bits only; tag travels along.
// - Larger goes left, smaller goes right.
// - Four parallel compares, registered each cycle.
// - Three more stages; keep the left four.
// - The four maxima are left unranked.
// - Output mux picks sorted or raw input.
// - Energy mode: raw words first, then sorted.
// - Four sorted results leave in one cycle.
// - Receiver mode never emits sorted data.
// - Electron mode: four inputs, two sorted outputs.
// - Second level finishes top four of sixteen.
// - Tag inputs may carry plain data instead.
// - Boundary-scan controller and instruction decoder included.
// - Extra tag bit on second cycle, when enabled.
`timescale 1ns/1ps
`default_nettype none
module tfs_top_four_sorter
    import tfs_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire tfs_mode_type     modeSel,
    input  wire logic             tagExtendEn,
    input  wire logic             tagAsData,
    input  wire tfs_pin_quad_type inQuad,
    input  wire logic             inValid,
    input  wire logic             inFirst,
    output logic                  inReady,
    output tfs_word_type          outWord,
    output logic                  outValid,
    input  wire logic             outReady,
    input  wire logic             scanClk,
    input  wire logic             scanMode,
    input  wire logic             scanIn,
    output logic                  scanOut,
    output logic                  scanOutEn
);

    ////////////////////////////////////////////////////////////////////////////////
    // State and helpers.

    typedef struct packed {
        tfs_quad_type              lowQuad;
        logic                      phase;
        logic                      pairSel;
        tfs_oct_type [STAGES:0]    pipe;
        logic        [STAGES:0]    pv;
        logic        [STAGES:0]    ps;
        tfs_word_type              head;
        tfs_word_type              spare;
        logic                      headV;
        logic                      spareV;
        logic                      ready;
    } tfs_core_type;

    tfs_core_type  s, n;
    logic          go;
    logic          take;
    logic          pop;
    logic          curPhase;
    logic          curPair;
    logic          rawMode;
    tfs_quad_type  extQuad;
    logic          emitV;
    tfs_word_type  emitW;

    // Pairs left lane i with right lane (i + rot) mod 4; the right index wraps on two bits.
    function automatic tfs_oct_type tfsCompareStage(input tfs_oct_type a, input logic [1:0] rot);
        tfs_oct_type r;
        logic [1:0]  j;
        r = a;
        for (int i = 0; i < LANES; i++)
        begin
            j = 2'(i) + rot;
            // Value-only compare; larger left; ties stay.
            if (a[LANES + int'(j)].val > a[i].val)
            begin
                r[i]                = a[LANES + int'(j)];
                r[LANES + int'(j)]  = a[i];
            end
        end
        return r;
    endfunction : tfsCompareStage

    function automatic logic tfsPairOk(input tfs_oct_type a, input logic [1:0] rot);
        logic       ok;
        logic [1:0] j;
        ok = 1'b1;
        for (int i = 0; i < LANES; i++)
        begin
            j = 2'(i) + rot;
            ok = ok & (a[i].val >= a[LANES + int'(j)].val);
        end
        return ok;
    endfunction : tfsPairOk

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb
    begin
        n        = s;
        go       = !(s.headV && s.spareV);
        take     = inValid && s.ready;
        pop      = s.headV && outReady;
        curPhase = inFirst ? 1'b0 : s.phase;
        curPair  = inFirst ? 1'b0 : s.pairSel;
        rawMode  = (modeSel != MODE_ELECTRON);
        emitV    = 1'b0;
        emitW    = '0;

        // Widen each pin operand to the ten-bit form.
        for (int i = 0; i < LANES; i++)
        begin
            extQuad[i].val = inQuad[i].val;
            extQuad[i].tag[PIN_TAG_W-1:0] = inQuad[i].tag;
            // Extra tag bit; tags used as data leave it clear.
            extQuad[i].tag[EXT_BIT] = tagExtendEn && !tagAsData && curPhase;
        end

        if (go)
        begin
            // Chain of four stages; one cycle each; all move together.
            for (int k = 1; k <= STAGES; k++)
            begin
                n.pipe[k] = tfsCompareStage(s.pipe[k-1], 2'(k - 1));
                n.pv[k]   = s.pv[k-1];
                n.ps[k]   = s.ps[k-1];
            end
            n.pv[0] = 1'b0;
            // Output mux: sorted left group or raw input.
            if (s.pv[STAGES])
            begin
                emitV       = 1'b1;
                // Only the left four survive; no ranking among them.
                emitW.data  = s.pipe[STAGES][LANES-1:0];
                emitW.sorted = 1'b1;
                emitW.second = s.ps[STAGES];
            end
            // Energy input shows on the outputs as it arrives; receiver too.
            else if (take && rawMode)
            begin
                emitV        = 1'b1;
                emitW.data   = extQuad;
                emitW.second = curPhase;
            end
        end

        // Two input cycles of four operands fill one eight-operand set.
        if (take)
        begin
            if (!curPhase)
            begin
                n.lowQuad = extQuad;
                n.phase   = 1'b1;
                n.pairSel = curPair;
            end
            else
            begin
                n.pipe[0] = {extQuad, s.lowQuad};
                // Permanent bypass never starts a sort.
                n.pv[0]   = (modeSel == MODE_ENERGY) || (modeSel == MODE_ELECTRON);
                // Second pair of a crossing marks the second output set.
                n.ps[0]   = curPair;
                n.phase   = 1'b0;
                n.pairSel = ~curPair;
            end
        end

        // Two-entry output buffer: the spare slot keeps a word while the receiver stalls.
        if (pop)
        begin
            n.head   = s.spare;
            n.headV  = s.spareV;
            n.spareV = 1'b0;
        end
        if (emitV)
        begin
            if (!n.headV)
            begin
                n.head  = emitW;
                n.headV = 1'b1;
            end
            else
            begin
                n.spare  = emitW;
                n.spareV = 1'b1;
            end
        end

        // Refuse input when the buffer will be full, or when a sorted word would collide
        // with a raw one in energy mode; the raw word would otherwise be lost.
        n.ready = !(n.headV && n.spareV) && !((modeSel == MODE_ENERGY) && n.pv[STAGES]);
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign inReady  = s.ready;
    // All four results leave in a single word.
    assign outWord  = s.head;
    assign outValid = s.headV;

    ////////////////////////////////////////////////////////////////////////////////
    // Boundary scan.

    // Scan controller and decoder shared with the sibling chips.
    tfs_scan_tap u_scan (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .scanClk   (scanClk),
        .scanMode  (scanMode),
        .scanIn    (scanIn),
        .scanOut   (scanOut),
        .scanOutEn (scanOutEn)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [7:0]  tagSumIn;
    logic [7:0]  tagSumOut;
    logic [5:0]  minLeft;
    logic [5:0]  maxRight;
    tfs_opr_type leftIn;
    logic        tieIn;
    logic        modeRecv;
    logic        modeElec;

    always_comb
    begin
        tagSumIn  = '0;
        tagSumOut = '0;
        minLeft   = '1;
        maxRight  = '0;
        for (int i = 0; i < OPERANDS; i++)
        begin
            tagSumIn  = tagSumIn + 8'(s.pipe[0][i].tag);
            tagSumOut = tagSumOut + 8'(s.pipe[1][i].tag);
        end
        for (int i = 0; i < LANES; i++)
        begin
            if (s.pipe[STAGES][i].val < minLeft)
            begin
                minLeft = s.pipe[STAGES][i].val;
            end
            if (s.pipe[STAGES][LANES+i].val > maxRight)
            begin
                maxRight = s.pipe[STAGES][LANES+i].val;
            end
        end
    end

    assign leftIn   = s.pipe[0][0];
    assign tieIn    = (s.pipe[0][0].val == s.pipe[0][LANES].val);
    assign modeRecv = (modeSel == MODE_RECEIVER);
    assign modeElec = (modeSel == MODE_ELECTRON);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence seqSetEnters;
        go && s.pv[0];
    endsequence

    sequence seqFourSteps;
        seqSetEnters ##1 go [*3];
    endsequence

    a_stage_one_order: assert property (s.pv[1] |-> tfsPairOk(s.pipe[1], 2'h0))
        else $error("first stage left operand smaller than its pair");
    a_stage_four_order: assert property (s.pv[STAGES] |-> tfsPairOk(s.pipe[STAGES], 2'h3))
        else $error("last stage pairing not ordered");
    a_tags_carried: assert property (seqSetEnters |=> tagSumOut == $past(tagSumIn))
        else $error("position tags changed inside a stage");
    a_chain_latency: assert property (seqFourSteps |=> s.pv[STAGES])
        else $error("sorted set not ready after four stages");
    a_maxima_kept: assert property (s.pv[STAGES] |-> minLeft >= maxRight)
        else $error("a right-hand operand beats a kept maximum");
    a_equal_keeps: assert property (seqSetEnters ##0 tieIn |=> s.pipe[1][0] == $past(leftIn))
        else $error("equal values swapped");
    a_energy_raw_out: assert property ((modeSel == MODE_ENERGY) && take |-> emitV && !emitW.sorted)
        else $error("energy input not passed straight out");
    a_receiver_unsorted: assert property (modeRecv [*6] |-> !(emitV && emitW.sorted))
        else $error("sorted word in permanent bypass");
    a_electron_sorted: assert property (modeElec [*6] |-> !(emitV && !emitW.sorted))
        else $error("raw word in electron mode");
    a_sorted_single: assert property (emitV && emitW.sorted |=> !(emitV && emitW.sorted))
        else $error("sorted words on consecutive cycles");
    a_tag_extend: assert property (take && curPhase && tagExtendEn && !tagAsData |-> extQuad[0].tag[EXT_BIT])
        else $error("extension tag bit missing on second cycle");
    a_buffer_holds: assert property (s.headV && !outReady |=> s.headV && s.head == $past(s.head))
        else $error("stalled output word changed");

endmodule : tfs_top_four_sorter
`default_nettype wire

/* tb/tfs_far_model.sv */
// Purpose: Downstream consumer of the sorter's output words.
// Assumes: A word is taken at the rising edge that sees outValid and outReady high.
// Notes:   slowMode holds readiness low four cycles in five to fill the buffer.
`timescale 1ns/1ps
`default_nettype none
module tfs_far_model
    import tfs_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         slowMode,
    input  wire logic         outValid,
    input  wire tfs_word_type outWord,
    output logic              outReady
);
    tfs_word_type got[$];
    int           tick = 0;

    ////////////////////////////////////////////////////////////////////////////
    // whole words taken
    // Readiness moves on the falling edge, so the next rising edge sees it settled.
    always @(negedge mclk)
    begin
        tick = tick + 1;
        outReady = !slowMode || (tick % 5 == 0);
        if (outValid === 1'h1 && outReady === 1'h1)
            got.push_back(outWord);
    end
endmodule : tfs_far_model
`default_nettype wire

/* tb/test_top_four_sorter.sv */
// Purpose: Self-checking bench of the top-four sorter.
// Assumes: Inputs change on falling mclk; the far model consumes the words.
// Notes:   Sorted words are judged as unordered sets of tagged operands.
`timescale 1ns/1ps
`default_nettype none
module test_top_four_sorter
    import tfs_pkg::*;
;
    logic             mclk        = 1'h0;
    logic             sysRst      = 1'h1;
    tfs_mode_type     modeSel     = MODE_ENERGY;
    logic             tagExtendEn = 1'h1;
    logic             tagAsData   = 1'h0;
    tfs_pin_quad_type inQuad      = '0;
    logic             inValid     = 1'h0;
    logic             inFirst     = 1'h0;
    logic             slowMode    = 1'h0;
    logic             scanClk     = 1'h0;
    logic             scanMode    = 1'h1;
    logic             scanOut;
    logic             scanOutEn;
    logic             inReady;
    tfs_word_type     outWord;
    logic             outValid;
    logic             outReady;
    int               nErrors     = 0;
    int               checksDone  = 0;

    always #2.5 mclk = ~mclk;

    tfs_top_four_sorter uut (.mclk(mclk), .sys_rst(sysRst), .modeSel(modeSel), .tagExtendEn(tagExtendEn),
        .tagAsData(tagAsData), .inQuad(inQuad), .inValid(inValid), .inFirst(inFirst), .inReady(inReady),
        .outWord(outWord), .outValid(outValid), .outReady(outReady), .scanClk(scanClk), .scanMode(scanMode),
        .scanIn(1'h0), .scanOut(scanOut), .scanOutEn(scanOutEn));

    tfs_far_model far (.mclk(mclk), .slowMode(slowMode), .outValid(outValid), .outWord(outWord),
        .outReady(outReady));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (nErrors == 0 && checksDone > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            nErrors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    function automatic tfs_opr_type widen(tfs_pin_opr_type p, logic sec);
        return {sec & tagExtendEn & ~tagAsData, p};
    endfunction : widen

    function automatic tfs_pin_quad_type quad(int v0, int v1, int v2, int v3, int t);
        tfs_pin_quad_type q;
        int               v[4];
        v = '{v0, v1, v2, v3};
        for (int i = 0; i < 4; i++)
        begin
            q[i].tag = 3'(i + t);
            q[i].val = 6'(v[i]);
        end
        return q;
    endfunction : quad

    function automatic tfs_word_type raw_word(tfs_pin_quad_type q, logic sec);
        tfs_word_type w;
        for (int i = 0; i < 4; i++)
            w.data[i] = widen(q[i], sec);
        w.sorted = 1'h0;
        w.second = sec;
        return w;
    endfunction : raw_word

    // The request stays up until a rising edge sees inReady high.
    task automatic put(input tfs_pin_quad_type q, input logic first);
        inQuad = q;
        inFirst = first;
        inValid = 1'h1;
        while (inReady !== 1'h1)
            @(negedge mclk);
        @(negedge mclk);
    endtask : put

    task automatic pair(input tfs_pin_quad_type a, input tfs_pin_quad_type b, input logic first,
                        output tfs_oct_type src);
        put(a, first);
        put(b, 1'h0);
        for (int i = 0; i < 4; i++)
        begin
            src[i] = widen(a[i], 1'h0);
            src[i+4] = widen(b[i], 1'h1);
        end
    endtask : pair

    task automatic fetch(output tfs_word_type w);
        int n;
        n = 0;
        while (far.got.size() == 0 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        w = (far.got.size() != 0) ? far.got.pop_front() : 'x;
    endtask : fetch

    // Ties make the chosen tags network dependent, so only set membership, values and the sorted and second flags are judged.
    task automatic chk_sorted(input tfs_oct_type src, input logic sec);
        tfs_word_type w;
        int           top[$];
        int           vals[$];
        bit [7:0]     used;
        int           hit;
        fetch(w);
        used = '0;
        hit = 0;
        for (int i = 0; i < 8; i++)
            top.push_back(src[i].val);
        top.rsort();
        for (int k = 0; k < 4; k++)
        begin
            vals.push_back(w.data[k].val);
            for (int i = 0; i < 8; i++)
                if (!used[i] && w.data[k] === src[i])
                begin
                    used[i] = 1'b1;
                    hit++;
                    break;
                end
        end
        vals.rsort();
        cmp({w.sorted, w.second}, {1'h1, sec});
        cmp(hit, 4);
        for (int k = 0; k < 4; k++)
            cmp(vals[k], top[k]);
    endtask : chk_sorted

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_energy;
        tfs_pin_quad_type a;
        tfs_pin_quad_type b;
        tfs_oct_type      s;
        tfs_word_type     w;
        a = quad(5, 63, 20, 20, 0);
        b = quad(20, 0, 63, 7, 4);
        pair(a, b, 1'h1, s);
        inValid = 1'h0;
        fetch(w);
        cmp(w, raw_word(a, 1'h0));
        fetch(w);
        cmp(w, raw_word(b, 1'h1));
        chk_sorted(s, 1'h0);
    endtask : t_energy

    task automatic t_electron;
        tfs_oct_type s0;
        tfs_oct_type s1;
        modeSel = MODE_ELECTRON;
        pair(quad(1, 2, 3, 4, 0), quad(60, 50, 40, 30, 4), 1'h1, s0);
        pair(quad(33, 9, 33, 9, 0), quad(9, 33, 9, 33, 4), 1'h0, s1);
        inValid = 1'h0;
        chk_sorted(s0, 1'h0);
        chk_sorted(s1, 1'h1);
    endtask : t_electron

    task automatic t_receiver;
        tfs_pin_quad_type a;
        tfs_pin_quad_type b;
        tfs_oct_type      s;
        tfs_word_type     w;
        for (int m = 0; m < 2; m++)
        begin
            // The spare code must behave as permanent bypass too.
            modeSel = m[0] ? MODE_SPARE : MODE_RECEIVER;
            tagAsData = m[0];
            a = quad(7, 62, 1, 33, 2);
            b = quad(63, 0, 12, 45, 5);
            pair(a, b, 1'h1, s);
            inValid = 1'h0;
            fetch(w);
            cmp(w, raw_word(a, 1'h0));
            fetch(w);
            cmp(w, raw_word(b, 1'h1));
        end
        repeat (20) @(negedge mclk);
        cmp(far.got.size(), 0);
        tagAsData = 1'h0;
    endtask : t_receiver

    // A slow consumer fills the two-entry buffer; no sorted word may be lost or reordered.
    task automatic t_stall;
        tfs_oct_type s[4];
        modeSel = MODE_ELECTRON;
        slowMode = 1'h1;
        for (int i = 0; i < 4; i++)
            pair(quad(10 * i, 3, 40, i, 0), quad(i, 50, 2, 60 - i, 4), 1'(~i), s[i]);
        inValid = 1'h0;
        for (int i = 0; i < 4; i++)
            chk_sorted(s[i], 1'(i));
        slowMode = 1'h0;
    endtask : t_stall

    // The scan clock stays high four mclk cycles and low eight, longer than the three the synchroniser needs.
    task automatic scan_tick(input logic tms, output logic tdo);
        scanMode = tms;
        repeat (4) @(negedge mclk);
        scanClk = 1'h1;
        repeat (4) @(negedge mclk);
        scanClk = 1'h0;
        repeat (4) @(negedge mclk);
        tdo = scanOut;
    endtask : scan_tick

    // Walks the controller into data shift; the identification word leaves lowest bit first.
    task automatic t_scan;
        logic [31:0] id;
        logic        b;
        id = '0;
        for (int k = 0; k < 35; k++)
        begin
            scan_tick(k == 1, b);
            if (k >= 3)
                id[k-3] = b;
        end
        cmp(id, SCAN_IDCODE);
        cmp(scanOutEn, 1'h1);
    endtask : t_scan

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge mclk);
        nErrors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (20) @(negedge mclk);
        cmp({inReady, outValid}, 2'h0);
        sysRst = 1'h0;
        repeat (2) @(negedge mclk);
        t_energy();
        t_electron();
        t_receiver();
        t_stall();
        cmp({scanOutEn, scanOut}, 2'h0);
        t_scan();
        tally_and_finish();
    end
endmodule : test_top_four_sorter
`default_nettype wire
